// file: verif/t8c_core_bench.sv
`timescale 1ns/100ps
`include "t8c_cfg.svh"

// ==========
// self-checking bench of the timer counter core
module t8c_core_bench;
	logic                clk;
	logic                arst_n;
	t8c_pkg::t8c_ctrl_t  ctrl;
	logic                cnt_we;
	logic [7:0]          cnt_wd;
	logic                cmp_a_we;
	logic [7:0]          cmp_wd;
	logic [2:0]          mask;
	logic [2:0]          clr;
	logic [2:0]          ack;
	logic                osc_en;
	logic                svc_en;
	logic                xtal;
	logic [7:0]          cnt;
	logic [7:0]          cmp_a;
	t8c_pkg::t8c_flags_t flags;
	logic                irq;
	logic                top;
	logic                bot;
	logic                cmp_b_we;
	logic [7:0]          cmp_b;
	logic                cmp_out_a;
	logic                cmp_out_b;
	logic                xtal2;
	int                  fail_count;
	int                  total_checks;
	int                  n;
	logic [7:0]          hi;

	t8c_core i_t8c_core (.i_clk_sys(clk), .i_arst_n(arst_n), .i_ctrl(ctrl), .i_counter_we(cnt_we),
		.i_counter_wdata(cnt_wd), .i_compare_a_we(cmp_a_we), .i_compare_b_we(cmp_b_we), .i_compare_wdata(cmp_wd),
		.i_irq_mask_reg(mask), .i_flag_clear(clr), .i_irq_ack(ack), .i_crystal_pin_1(xtal),
		.i_ext_clk_pin(1'h0), .o_crystal_pin_2(xtal2), .o_counter_value(cnt), .o_compare_value_a(cmp_a),
		.o_compare_value_b(cmp_b), .o_irq_flag_reg(flags), .o_irq(irq), .o_compare_out_a(cmp_out_a),
		.o_compare_out_b(cmp_out_b), .o_top(top), .o_bottom(bot));

	t8c_cpu_model i_t8c_cpu_model (.i_clk_sys(clk), .i_osc_en(osc_en), .i_svc_en(svc_en), .i_irq(irq),
		.i_pending(flags & mask), .o_crystal(xtal), .o_ack(ack));

	always #5 clk = ~clk;

	// ==========
	// helpers
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		total_checks++;
		if (got !== exp) begin
			$display("Error at %0t ns: got %h expected %h", $time, got, exp);
			fail_count++;
		end
	endtask

	task automatic cyc(input int k);
		repeat (k) @(posedge clk);
		#1;
	endtask

	task automatic wr_cnt(input logic [7:0] v);
		cnt_we = 1'h1;
		cnt_wd = v;
		cyc(1);
		cnt_we = 1'h0;
	endtask

	task automatic wr_a(input logic [7:0] v);
		cmp_a_we = 1'h1;
		cmp_wd = v;
		cyc(1);
		cmp_a_we = 1'h0;
	endtask

	task automatic mode_set(input logic [2:0] wm, input logic [2:0] cs);
		ctrl.waveform_mode_field = wm;
		ctrl.clock_select_field = cs;
	endtask

	task automatic flags_clear;
		clr = 3'h7;
		cyc(1);
		clr = 3'h0;
		cyc(2);
	endtask

	task automatic results;
		$display("checks %0d mismatches %0d", total_checks, fail_count);
		if (fail_count == 0 && total_checks > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask

	// ==========
	// scenarios
	task automatic t_stop;
		chk(cnt, 8'h00);
		chk(bot, 8'h01);
		wr_cnt(8'h5A);
		cyc(4);
		chk(cnt, 8'h5A);
		chk(bot, 8'h00);
	endtask

	task automatic t_wrap;
		mask = 3'h1;
		wr_cnt(8'hFC);
		mode_set(`T8C_WM_NORMAL, `T8C_CS_DIV1);
		for (n = 0; n < 8 && cnt !== 8'hFF; n++) cyc(1);
		chk(top, 8'h01);
		chk(flags, 8'h00);
		cyc(1);
		chk(cnt, 8'h00);
		chk(flags, 8'h01);
		cyc(1);
		chk(irq, 8'h01);
		mode_set(`T8C_WM_NORMAL, `T8C_CS_STOP);
		clr = 3'h6;
		cyc(1);
		clr = 3'h0;
		cyc(2);
		chk(flags, 8'h01);
		flags_clear();
		chk(flags, 8'h00);
		chk(irq, 8'h00);
	endtask

	task automatic t_prio;
		mode_set(`T8C_WM_NORMAL, `T8C_CS_DIV1);
		wr_cnt(8'h40);
		cyc(1);
		chk(cnt, 8'h40);
		cyc(1);
		chk(cnt, 8'h41);
		mode_set(`T8C_WM_NORMAL, `T8C_CS_STOP);
	endtask

	task automatic t_cmp;
		mask = 3'h0;
		ctrl.compare_mode_a = `T8C_COM_SET;
		ctrl.compare_mode_b = `T8C_COM_SET;
		cmp_b_we = 1'h1;
		wr_a(8'h10);
		cmp_b_we = 1'h0;
		wr_cnt(8'h0E);
		mode_set(`T8C_WM_NORMAL, `T8C_CS_DIV1);
		for (n = 0; n < 8 && flags.compare_flag_a !== 1'h1; n++) cyc(1);
		chk(cnt, 8'h11);
		chk(cmp_a, 8'h10);
		chk(cmp_b, 8'h10);
		chk(flags, 8'h06);
		chk(cmp_out_a, 8'h01);
		chk(cmp_out_b, 8'h01);
		cyc(2);
		chk(irq, 8'h00);
		mask = 3'h6;
		svc_en = 1'h1;
		cyc(6);
		chk(flags, 8'h00);
		svc_en = 1'h0;
		mode_set(`T8C_WM_NORMAL, `T8C_CS_STOP);
	endtask

	task automatic t_ctc;
		wr_a(8'h05);
		wr_cnt(8'h00);
		mode_set(`T8C_WM_CTC, `T8C_CS_DIV1);
		hi = 8'h00;
		repeat (20) begin
			cyc(1);
			if (cnt > hi) hi = cnt;
		end
		chk(hi, 8'h05);
		mode_set(`T8C_WM_NORMAL, `T8C_CS_STOP);
		flags_clear();
	endtask

	task automatic t_pwr;
		wr_cnt(8'h22);
		ctrl.timer_power_off_bit = 1'h1;
		mode_set(`T8C_WM_NORMAL, `T8C_CS_DIV1);
		cyc(1);
		wr_cnt(8'h77);
		cyc(4);
		chk(cnt, 8'h22);
		ctrl.timer_power_off_bit = 1'h0;
		mode_set(`T8C_WM_NORMAL, `T8C_CS_STOP);
	endtask

	task automatic t_async;
		wr_cnt(8'h00);
		ctrl.async_clock_select = 1'h1;
		mode_set(`T8C_WM_NORMAL, `T8C_CS_DIV1);
		osc_en = 1'h1;
		cyc(100);
		chk(cnt > 8'h09 && cnt < 8'h10, 8'h01);
		osc_en = 1'h0;
		mode_set(`T8C_WM_NORMAL, `T8C_CS_STOP);
		ctrl.async_clock_select = 1'h0;
		flags_clear();
		cyc(5);
		chk(xtal2, 8'h01);
	endtask

	task automatic t_buf;
		mode_set(`T8C_WM_FAST_MAX, `T8C_CS_STOP);
		wr_a(8'h33);
		cyc(3);
		chk(cmp_a, 8'h05);
		mode_set(`T8C_WM_FAST_MAX, `T8C_CS_DIV1);
		for (n = 0; n < 300 && cmp_a !== 8'h33; n++) cyc(1);
		chk(cmp_a, 8'h33);
	endtask

	// ==========
	// main sequence and watchdog
	initial begin
		clk = 1'h0;
		arst_n = 1'h0;
		ctrl = '0;
		{cnt_we, cmp_a_we, cmp_b_we, osc_en, svc_en} = 5'h00;
		{cnt_wd, cmp_wd} = 16'h0000;
		{mask, clr} = 6'h00;
		fail_count = 0;
		total_checks = 0;
		repeat (8) @(posedge clk);
		#1 arst_n = 1'h1;
		cyc(2);
		t_stop();
		t_wrap();
		t_prio();
		t_cmp();
		t_ctc();
		t_pwr();
		t_async();
		t_buf();
		results();
	end

	initial begin
		#20000;
		fail_count++;
		results();
	end
endmodule

// file: verif/t8c_core_chk.sv
`timescale 1ns/100ps
`include "t8c_cfg.svh"

// ==========
// port checker of the timer counter core
module t8c_core_chk #(
	parameter int CNT_W = 8
) (
	input wire logic                i_clk_sys,
	input wire logic                i_arst_n,
	input wire t8c_pkg::t8c_ctrl_t  i_ctrl,
	input wire logic                i_counter_we,
	input wire logic [CNT_W-1:0]    i_counter_wdata,
	input wire logic                i_compare_a_we,
	input wire logic [2:0]          i_irq_mask_reg,
	input wire logic [2:0]          i_flag_clear,
	input wire logic [2:0]          i_irq_ack,
	input wire logic [CNT_W-1:0]    o_counter_value,
	input wire logic [CNT_W-1:0]    o_compare_value_a,
	input wire t8c_pkg::t8c_flags_t o_irq_flag_reg,
	input wire logic                o_irq,
	input wire logic                o_top,
	input wire logic                o_bottom
);
	logic up_ff;

	default clocking cb @(posedge i_clk_sys); endclocking
	default disable iff (!i_arst_n);

	// normal mode, tick every cycle, no counter write
	wire run0 = i_ctrl.waveform_mode_field == `T8C_WM_NORMAL && i_ctrl.clock_select_field == `T8C_CS_DIV1
		&& !i_ctrl.timer_power_off_bit && !i_ctrl.async_clock_select && !i_counter_we;

	// first settled cycle after reset release
	always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
		if (!i_arst_n) begin
			up_ff <= 1'h0;
		end else begin
			up_ff <= 1'h1;
		end
	end

	a_top_max: assert property (up_ff |-> o_top == (o_counter_value == `T8C_MAX))
		else $error("top indication wrong");
	a_bottom_zero: assert property (up_ff |-> o_bottom == (o_counter_value == `T8C_BOTTOM))
		else $error("bottom indication wrong");
	a_stop_hold: assert property (up_ff && i_ctrl.clock_select_field == `T8C_CS_STOP && !i_counter_we
		|-> ##2 $stable(o_counter_value)) else $error("stopped counter moved");
	a_power_hold: assert property (up_ff && i_ctrl.timer_power_off_bit |-> ##2 $stable(o_counter_value))
		else $error("powered-off counter moved");
	a_write_wins: assert property (i_counter_we && !i_ctrl.timer_power_off_bit
		|-> ##2 o_counter_value == $past(i_counter_wdata, 2)) else $error("counter write lost");
	a_tick_count: assert property (up_ff && run0
		|-> ##2 o_counter_value == CNT_W'($past(o_counter_value) + 1'h1)) else $error("count step wrong");
	a_ovf_wrap: assert property (up_ff && $past(run0, 2) && $past(o_counter_value) == `T8C_MAX
		&& o_counter_value == `T8C_BOTTOM |-> o_irq_flag_reg.overflow_flag) else $error("no overflow flag");
	a_irq_gate: assert property (up_ff && $stable(i_irq_mask_reg)
		|=> o_irq == |(o_irq_flag_reg & $past(i_irq_mask_reg))) else $error("irq gating wrong");
	a_flag_clear: assert property (up_ff
		|-> ($past(o_irq_flag_reg) & ~o_irq_flag_reg & ~$past(i_flag_clear | i_irq_ack, 2)) == 3'h0)
		else $error("flag dropped by itself");
	a_cmp_flag: assert property (up_ff && $past(run0, 2) && $past(run0, 3) && !$past(i_compare_a_we, 2)
		&& !$past(i_compare_a_we, 3) && $past(o_counter_value == o_compare_value_a)
		|-> o_irq_flag_reg.compare_flag_a) else $error("no compare flag");
endmodule

bind t8c_core t8c_core_chk #(.CNT_W(CNT_W)) i_t8c_core_chk (.i_clk_sys, .i_arst_n, .i_ctrl, .i_counter_we,
	.i_counter_wdata, .i_compare_a_we, .i_irq_mask_reg, .i_flag_clear, .i_irq_ack, .o_counter_value,
	.o_compare_value_a, .o_irq_flag_reg, .o_irq, .o_top, .o_bottom);

// file: verif/t8c_cpu_model.sv
`timescale 1ns/100ps

// ==========
// processor side: watch crystal and interrupt service
module t8c_cpu_model (
	input  wire logic       i_clk_sys,
	input  wire logic       i_osc_en,
	input  wire logic       i_svc_en,
	input  wire logic       i_irq,
	input  wire logic [2:0] i_pending,
	output logic            o_crystal,
	output logic [2:0]      o_ack
);
	// crystal swings only while enabled, else rests low
	initial o_crystal = 1'h0;
	always #37 o_crystal = i_osc_en & ~o_crystal;

	// service routine acknowledges every pending enabled source
	initial o_ack = 3'h0;
	always @(posedge i_clk_sys) begin
		#1;
		o_ack = (i_svc_en && i_irq) ? i_pending : 3'h0;
	end
endmodule

// file: verilog/t8c_cfg.svh
`ifndef T8C_CFG_SVH
`define T8C_CFG_SVH

// counter limits
`define T8C_BOTTOM        8'h00
`define T8C_MAX           8'hFF
`define T8C_WIDTH         8

// waveform mode field encodings
`define T8C_WM_NORMAL     3'h0
`define T8C_WM_PC_MAX     3'h1
`define T8C_WM_CTC        3'h2
`define T8C_WM_FAST_MAX   3'h3
`define T8C_WM_PC_OCRA    3'h5
`define T8C_WM_FAST_OCRA  3'h7

// clock select field encodings
`define T8C_CS_STOP       3'h0
`define T8C_CS_DIV1       3'h1
`define T8C_CS_DIV8       3'h2
`define T8C_CS_DIV64      3'h3
`define T8C_CS_DIV256     3'h4
`define T8C_CS_DIV1024    3'h5
`define T8C_CS_EXT_FALL   3'h6
`define T8C_CS_EXT_RISE   3'h7

// prescaler taps (bit index whose carry marks a divided tick)
`define T8C_PS_WIDTH      10
`define T8C_PS_TAP8       3'h2
`define T8C_PS_TAP64      3'h5
`define T8C_PS_TAP256     4'h7
`define T8C_PS_TAP1024    4'h9

// flag and mask bit positions
`define T8C_FLAG_OVF      0
`define T8C_FLAG_CMPA     1
`define T8C_FLAG_CMPB     2
`define T8C_FLAG_W        3

// compare output mode encodings
`define T8C_COM_OFF       2'h0
`define T8C_COM_TOGGLE    2'h1
`define T8C_COM_CLEAR     2'h2
`define T8C_COM_SET       2'h3

`endif

// file: verilog/t8c_core.sv
`timescale 1ns/100ps
`include "t8c_cfg.svh"

// Function
// - counter and both compare registers are eight bits wide
// - bottom means the counter value is zero
// - max means the counter value is 255
// - top is max or compare register A, chosen by the waveform mode
// - timer clock comes from io clock, or crystal pins when async select set, or external clock pin edges in the two ext selects
// - clock select zero stops the counter completely
// - each timer tick clears, increments or decrements the counter by mode
// - software reads the counter at any time; writes land only while the power-off bit is zero
// - a software counter write beats a same-cycle count or clear
// - three-bit waveform mode picks the counting sequence
// - overflow flag set according to mode and can request an interrupt
// - both compare registers are compared continuously; match sets its flag
// - both compare registers are double buffered
// - all requests visible as flags and gated by their own mask bit
// - timer runs only while its power-off bit is zero
// - compare results drive the waveform outputs of both channels
// - max and bottom indications (o_top, o_bottom) are produced for the waveform logic
// - a match sets the compare flag on the following timer tick
// - buffering only in pwm modes; normal and ctc write directly
// - mode zero counts up, wraps 255 to zero, overflow flag on the wrap
// - mode two clears the counter on a match with compare register A
module t8c_core #(
	parameter int CNT_W = `T8C_WIDTH
) (
	input  wire logic             i_clk_sys,
	input  wire logic             i_arst_n,
	input  wire t8c_pkg::t8c_ctrl_t i_ctrl,
	input  wire logic             i_counter_we,
	input  wire logic [CNT_W-1:0] i_counter_wdata,
	input  wire logic             i_compare_a_we,
	input  wire logic             i_compare_b_we,
	input  wire logic [CNT_W-1:0] i_compare_wdata,
	input  wire logic [2:0]       i_irq_mask_reg,
	input  wire logic [2:0]       i_flag_clear,
	input  wire logic [2:0]       i_irq_ack,
	input  wire logic             i_crystal_pin_1,
	input  wire logic             i_ext_clk_pin,
	output logic                  o_crystal_pin_2,
	output logic [CNT_W-1:0]      o_counter_value,
	output logic [CNT_W-1:0]      o_compare_value_a,
	output logic [CNT_W-1:0]      o_compare_value_b,
	output t8c_pkg::t8c_flags_t   o_irq_flag_reg,
	output logic                  o_irq,
	output logic                  o_compare_out_a,
	output logic                  o_compare_out_b,
	output logic                  o_top,
	output logic                  o_bottom
);

	// ==========================================================
	// pin synchronisers
	// ==========================================================
	logic [1:0]           xtal_sync_ff;
	logic [1:0]           ext_sync_ff;
	logic                 xtal_last_ff;
	logic                 ext_last_ff;
	logic                 xtal_rise;
	logic                 ext_rise;
	logic                 ext_fall;

	// two stages before any logic looks at the pins
	always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
		if (!i_arst_n) begin
			xtal_sync_ff <= 2'h0;
			ext_sync_ff  <= 2'h0;
			xtal_last_ff <= 1'b0;
			ext_last_ff  <= 1'b0;
		end else begin
			xtal_sync_ff <= {xtal_sync_ff[0], i_crystal_pin_1};
			ext_sync_ff  <= {ext_sync_ff[0], i_ext_clk_pin};
			xtal_last_ff <= xtal_sync_ff[1];
			ext_last_ff  <= ext_sync_ff[1];
		end
	end

	assign xtal_rise = xtal_sync_ff[1] & ~xtal_last_ff;
	assign ext_rise  = ext_sync_ff[1] & ~ext_last_ff;
	assign ext_fall  = ~ext_sync_ff[1] & ext_last_ff;

	// oscillator feedback pin: inverted crystal level
	always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
		if (!i_arst_n) begin
			o_crystal_pin_2 <= 1'b0;
		end else begin
			o_crystal_pin_2 <= ~xtal_sync_ff[1];
		end
	end

	// ==========================================================
	// clock select and prescaler
	// ==========================================================
	logic                      powered;
	logic                      base_tick;
	logic [`T8C_PS_WIDTH-1:0]  presc_ff;
	logic [`T8C_PS_WIDTH-1:0]  presc_carry;
	logic                      tick;

	assign powered   = ~i_ctrl.timer_power_off_bit;
	// io clock by default, crystal edges in async operation
	assign base_tick = i_ctrl.async_clock_select ? xtal_rise : 1'b1;

	// free-running divider, held clear while stopped
	always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
		if (!i_arst_n) begin
			presc_ff <= '0;
		end else if (!powered || i_ctrl.clock_select_field == `T8C_CS_STOP) begin
			presc_ff <= '0;
		end else if (base_tick) begin
			presc_ff <= presc_ff + `T8C_PS_WIDTH'(1);
		end
	end

	// a tap carries when all bits up to it are ones
	always_comb begin
		presc_carry[0] = base_tick & presc_ff[0];
		for (int i = 1; i < `T8C_PS_WIDTH; i++) begin
			presc_carry[i] = presc_carry[i-1] & presc_ff[i];
		end
	end

	// one tick per timer clock; none when stopped or powered off
	always_comb begin
		case (i_ctrl.clock_select_field)
			`T8C_CS_STOP:     tick = 1'b0;
			`T8C_CS_DIV1:     tick = base_tick;
			`T8C_CS_DIV8:     tick = presc_carry[`T8C_PS_TAP8];
			`T8C_CS_DIV64:    tick = presc_carry[`T8C_PS_TAP64];
			`T8C_CS_DIV256:   tick = presc_carry[`T8C_PS_TAP256];
			`T8C_CS_DIV1024:  tick = presc_carry[`T8C_PS_TAP1024];
			`T8C_CS_EXT_FALL: tick = ext_fall;
			`T8C_CS_EXT_RISE: tick = ext_rise;
			default:          tick = 1'b0;
		endcase
		tick = tick & powered;
	end

	// ==========================================================
	// mode decode
	// ==========================================================
	t8c_pkg::t8c_seq_t    seq;
	logic                 top_is_a;
	logic [CNT_W-1:0]     top_val;

	// counting sequence from the three-bit field
	always_comb begin
		case (i_ctrl.waveform_mode_field)
			`T8C_WM_NORMAL:    seq = t8c_pkg::T8C_SEQ_NORMAL;
			`T8C_WM_PC_MAX:    seq = t8c_pkg::T8C_SEQ_PHASE;
			`T8C_WM_CTC:       seq = t8c_pkg::T8C_SEQ_CTC;
			`T8C_WM_FAST_MAX:  seq = t8c_pkg::T8C_SEQ_FAST;
			`T8C_WM_PC_OCRA:   seq = t8c_pkg::T8C_SEQ_PHASE;
			`T8C_WM_FAST_OCRA: seq = t8c_pkg::T8C_SEQ_FAST;
			default:           seq = t8c_pkg::T8C_SEQ_NORMAL;
		endcase
		top_is_a = (i_ctrl.waveform_mode_field == `T8C_WM_CTC) ||
		           (i_ctrl.waveform_mode_field == `T8C_WM_PC_OCRA) ||
		           (i_ctrl.waveform_mode_field == `T8C_WM_FAST_OCRA);
	end

	// ==========================================================
	// counter unit
	// ==========================================================
	logic [CNT_W-1:0]     cnt_ff;
	logic [CNT_W-1:0]     nxt_cnt;
	logic                 down_ff;
	logic                 nxt_down;
	logic [CNT_W-1:0]     cmp_a_ff;
	logic [CNT_W-1:0]     cmp_b_ff;
	logic                 at_top;
	logic                 at_bottom;
	logic                 ovf_evt;

	assign top_val   = top_is_a ? cmp_a_ff : CNT_W'(`T8C_MAX);
	assign at_top    = (cnt_ff == top_val);
	assign at_bottom = (cnt_ff == CNT_W'(`T8C_BOTTOM));

	// next count and direction per sequence
	always_comb begin
		nxt_cnt  = cnt_ff;
		nxt_down = down_ff;
		ovf_evt  = 1'b0;
		case (seq)
			t8c_pkg::T8C_SEQ_NORMAL: begin
				nxt_cnt  = cnt_ff + CNT_W'(1);
				nxt_down = 1'b0;
				ovf_evt  = (cnt_ff == CNT_W'(`T8C_MAX));
			end
			t8c_pkg::T8C_SEQ_CTC: begin
				nxt_down = 1'b0;
				nxt_cnt  = at_top ? CNT_W'(`T8C_BOTTOM) : cnt_ff + CNT_W'(1);
				ovf_evt  = (cnt_ff == CNT_W'(`T8C_MAX));
			end
			t8c_pkg::T8C_SEQ_FAST: begin
				nxt_down = 1'b0;
				nxt_cnt  = at_top ? CNT_W'(`T8C_BOTTOM) : cnt_ff + CNT_W'(1);
				ovf_evt  = at_top;
			end
			t8c_pkg::T8C_SEQ_PHASE: begin
				if (down_ff) begin
					nxt_cnt  = at_bottom ? cnt_ff + CNT_W'(1) : cnt_ff - CNT_W'(1);
					nxt_down = at_bottom ? 1'b0 : 1'b1;
					ovf_evt  = at_bottom;
				end else begin
					nxt_cnt  = at_top ? cnt_ff - CNT_W'(1) : cnt_ff + CNT_W'(1);
					nxt_down = at_top;
				end
			end
			default: begin
				nxt_cnt = cnt_ff;
			end
		endcase
	end

	// counter register; software write wins over count or clear
	always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
		if (!i_arst_n) begin
			cnt_ff  <= CNT_W'(`T8C_BOTTOM);
			down_ff <= 1'b0;
		end else if (i_counter_we && powered) begin
			cnt_ff <= i_counter_wdata;
		end else if (tick) begin
			cnt_ff  <= nxt_cnt;
			down_ff <= nxt_down;
		end
	end

	// ==========================================================
	// compare registers with double buffering
	// ==========================================================
	logic [CNT_W-1:0]     buf_a_ff;
	logic [CNT_W-1:0]     buf_b_ff;
	logic                 pwm_mode;
	logic                 upd_point;

	assign pwm_mode  = (seq == t8c_pkg::T8C_SEQ_FAST) || (seq == t8c_pkg::T8C_SEQ_PHASE);
	// fast pwm reloads at top, phase correct at top while counting up
	assign upd_point = tick && ((seq == t8c_pkg::T8C_SEQ_FAST) ? at_top : (at_top && !down_ff));

	// buffer writes land while powered; active copy follows buffer when allowed
	always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
		if (!i_arst_n) begin
			buf_a_ff <= '0;
			buf_b_ff <= '0;
			cmp_a_ff <= '0;
			cmp_b_ff <= '0;
		end else if (powered) begin
			if (i_compare_a_we) begin
				buf_a_ff <= i_compare_wdata;
			end
			if (i_compare_b_we) begin
				buf_b_ff <= i_compare_wdata;
			end
			if (!pwm_mode) begin
				cmp_a_ff <= i_compare_a_we ? i_compare_wdata : buf_a_ff;
				cmp_b_ff <= i_compare_b_we ? i_compare_wdata : buf_b_ff;
			end else if (upd_point) begin
				cmp_a_ff <= buf_a_ff;
				cmp_b_ff <= buf_b_ff;
			end
		end
	end

	// ==========================================================
	// match detection and flags
	// ==========================================================
	logic                 block_ff;
	logic                 match_a;
	logic                 match_b;
	t8c_pkg::t8c_flags_t  flags_ff;
	logic [2:0]           set_vec;
	logic [2:0]           clr_vec;

	assign match_a = (cnt_ff == cmp_a_ff);
	assign match_b = (cnt_ff == cmp_b_ff);

	// a counter write blocks matches on the next timer tick
	always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
		if (!i_arst_n) begin
			block_ff <= 1'b0;
		end else if (i_counter_we && powered) begin
			block_ff <= 1'b1;
		end else if (tick) begin
			block_ff <= 1'b0;
		end
	end

	always_comb begin
		set_vec                  = '0;
		set_vec[`T8C_FLAG_OVF]   = tick && !(i_counter_we && powered) && ovf_evt;
		set_vec[`T8C_FLAG_CMPA]  = tick && !block_ff && match_a;
		set_vec[`T8C_FLAG_CMPB]  = tick && !block_ff && match_b;
		clr_vec                  = i_flag_clear | i_irq_ack;
	end

	// set beats clear in the same cycle
	always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
		if (!i_arst_n) begin
			flags_ff <= '0;
		end else begin
			flags_ff <= (flags_ff & ~clr_vec) | set_vec;
		end
	end

	// ==========================================================
	// waveform outputs
	// ==========================================================
	logic                 wave_a_ff;
	logic                 wave_b_ff;

	// next output level for one channel from mode and match
	function automatic logic t8c_wave(input logic cur, input logic [1:0] com,
		input t8c_pkg::t8c_seq_t sq, input logic hit, input logic bot, input logic dn);
		logic nv;
		nv = cur;
		if (sq == t8c_pkg::T8C_SEQ_NORMAL || sq == t8c_pkg::T8C_SEQ_CTC) begin
			if (hit) begin
				case (com)
					`T8C_COM_TOGGLE: nv = ~cur;
					`T8C_COM_CLEAR:  nv = 1'b0;
					`T8C_COM_SET:    nv = 1'b1;
					default:         nv = cur;
				endcase
			end
		end else if (com == `T8C_COM_CLEAR || com == `T8C_COM_SET) begin
			if (sq == t8c_pkg::T8C_SEQ_FAST) begin
				if (hit) begin
					nv = (com == `T8C_COM_SET);
				end else if (bot) begin
					nv = (com == `T8C_COM_CLEAR);
				end
			end else if (hit) begin
				nv = (com == `T8C_COM_SET) ^ dn;
			end
		end
		return nv;
	endfunction

	always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
		if (!i_arst_n) begin
			wave_a_ff <= 1'b0;
			wave_b_ff <= 1'b0;
		end else if (tick) begin
			wave_a_ff <= t8c_wave(wave_a_ff, i_ctrl.compare_mode_a, seq, match_a && !block_ff,
			                      at_bottom, down_ff);
			wave_b_ff <= t8c_wave(wave_b_ff, i_ctrl.compare_mode_b, seq, match_b && !block_ff,
			                      at_bottom, down_ff);
		end
	end

	// ==========================================================
	// registered outputs
	// ==========================================================
	always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
		if (!i_arst_n) begin
			o_counter_value   <= '0;
			o_compare_value_a <= '0;
			o_compare_value_b <= '0;
			o_irq_flag_reg    <= '0;
			o_irq             <= 1'b0;
			o_compare_out_a   <= 1'b0;
			o_compare_out_b   <= 1'b0;
			o_top             <= 1'b0;
			o_bottom          <= 1'b0;
		end else begin
			o_counter_value   <= cnt_ff;
			o_compare_value_a <= cmp_a_ff;
			o_compare_value_b <= cmp_b_ff;
			o_irq_flag_reg    <= flags_ff;
			o_irq             <= |(flags_ff & i_irq_mask_reg);
			o_compare_out_a   <= (i_ctrl.compare_mode_a != `T8C_COM_OFF) & wave_a_ff;
			o_compare_out_b   <= (i_ctrl.compare_mode_b != `T8C_COM_OFF) & wave_b_ff;
			o_top             <= (cnt_ff == CNT_W'(`T8C_MAX));
			o_bottom          <= at_bottom;
		end
	end

endmodule

// file: verilog/t8c_pkg.sv
package t8c_pkg;

	// control fields written by software
	typedef struct packed {
		logic       timer_power_off_bit;
		logic       async_clock_select;
		logic [2:0] waveform_mode_field;
		logic [2:0] clock_select_field;
		logic [1:0] compare_mode_a;
		logic [1:0] compare_mode_b;
	} t8c_ctrl_t;

	// interrupt flag set
	typedef struct packed {
		logic compare_flag_b;
		logic compare_flag_a;
		logic overflow_flag;
	} t8c_flags_t;

	// counting sequence class
	typedef enum logic [1:0] {
		T8C_SEQ_NORMAL = 2'b00,
		T8C_SEQ_CTC    = 2'b01,
		T8C_SEQ_FAST   = 2'b10,
		T8C_SEQ_PHASE  = 2'b11
	} t8c_seq_t;

endpackage
